/* pfp_pkg.sv */
// Constants for the port function and pull-up select block.
// Assumes an AXI4-Lite master with 32-bit data and a 250 MHz core clock.
//
// Summary of operation
// - Upper sixteen bits always read as zero
// - Select bit zero hands pin to GPIO
// - Select bit one hands pin to peripheral
// - Lower sixteen bits read back last write
// - Bit n of a port drives pin n
// - Port 0 select resets 0x001F, others zero
// - Absent pins: software writes only reset value
// - Port 4 pins 6 to 9 ignored here
// - Port 0 bits 4:0 survive deep standby
// - CEC pin bits survive while routing active
// - Pull-up per port except port 8; port 0 resets 0x001F
// - Pull-up bit one connects resistor on inputs
// - Pull-up drops one cycle after a pin starts driving
package pfp_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] PFP_FS_BASE      = 12'h000;  // Function-select bank
  localparam logic [11:0] PFP_PU_BASE      = 12'h040;  // Pull-up bank
  localparam int          PFP_BANK_LSB     = 6;        // Bank selector low bit
  localparam int          PFP_IDX_LSB      = 2;        // Port index low bit
  localparam logic [5:0]  PFP_BANK_FS      = 6'h00;
  localparam logic [5:0]  PFP_BANK_PU      = 6'h01;

  // ==========================================================
  // Reset values and fixed masks
  localparam logic [15:0] PFP_P0_RST       = 16'h001F;  // Debug port pins
  localparam logic [15:0] PFP_PX_RST       = 16'h0000;
  localparam logic [15:0] PFP_P0_KEEP      = 16'h001F;  // Kept over deep standby
  localparam int          PFP_VB_PORT      = 4;
  localparam logic [15:0] PFP_VB_MASK      = 16'h03C0;  // Pins 6..9, backup domain
  localparam int          PFP_NO_PU_PORT   = 8;
  localparam logic [15:0] PFP_RSV_ZERO     = 16'h0000;
  localparam logic [1:0]  PFP_ROUTE_OFF    = 2'h0;

  // ==========================================================
  // Bus responses and timing
  localparam logic [1:0]  PFP_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  PFP_RESP_DECERR  = 2'h3;
  localparam int          PFP_CLK_NS       = 4;

endpackage : pfp_pkg

/* pfp_port_config.sv */
// Port function select and pull-up enable registers, one pair per port; port 8 has no pull-up register.
// Assumes AXI4-Lite software access, a deep standby reset pulse from the
// power controller, and pads that report which pins currently drive.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module pfp_port_config #(
  parameter int          NPORT         = 16,
  parameter int          PINS          = 16,
  parameter int          CEC_PORT      = 0,        // Port holding CEC pins
  parameter logic [15:0] CEC_PIN_MASK  = 16'h0000, // CEC pin positions
  parameter logic        CEC_RETAIN_EN = 1'b0      // Product keeps CEC bits
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   dstby_reset,
  input  wire logic [1:0]             cec_pin_route_field_a,
  input  wire logic [1:0]             cec_pin_route_field_b,
  input  wire logic [NPORT*PINS-1:0]  pin_output_active,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output var  logic [NPORT*PINS-1:0]  pin_function_select,
  output var  logic [NPORT*PINS-1:0]  pin_gpio_select,
  output var  logic [NPORT*PINS-1:0]  pin_pullup_enable
);

  // ==========================================================
  // Write channel holding registers
  logic [11:0]            awaddr_r;
  logic                   aw_held_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   w_held_r;
  logic [PINS-1:0]        fs_r [NPORT];
  logic [PINS-1:0]        pu_w [NPORT];
  logic [NPORT*PINS-1:0]  fs_eff;
  logic [NPORT*PINS-1:0]  pu_flat;
  logic [NPORT*PINS-1:0]  vb_flat;
  logic [NPORT-1:0]       wr_fs_en;
  logic [NPORT-1:0]       wr_pu_en;

  // Handshake and decode terms
  wire             aw_hs    = s_axi_awvalid & s_axi_awready;
  wire             w_hs     = s_axi_wvalid & s_axi_wready;
  wire             ar_hs    = s_axi_arvalid & s_axi_arready;
  wire             do_wr    = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire [5:0]       wr_bank  = awaddr_r[11:pfp_pkg::PFP_BANK_LSB];
  wire [3:0]       wr_idx   = awaddr_r[pfp_pkg::PFP_BANK_LSB-1:pfp_pkg::PFP_IDX_LSB];
  wire             wr_fs    = (wr_bank == pfp_pkg::PFP_BANK_FS);
  wire             wr_pu    = (wr_bank == pfp_pkg::PFP_BANK_PU);
  wire [PINS-1:0]  wr_mask  = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [5:0]       rd_bank  = s_axi_araddr[11:pfp_pkg::PFP_BANK_LSB];
  wire [3:0]       rd_idx   = s_axi_araddr[pfp_pkg::PFP_BANK_LSB-1:pfp_pkg::PFP_IDX_LSB];
  wire             rd_fs    = (rd_bank == pfp_pkg::PFP_BANK_FS);
  wire             rd_pu    = (rd_bank == pfp_pkg::PFP_BANK_PU);
  wire             cec_on   = CEC_RETAIN_EN &
                              ((cec_pin_route_field_a != pfp_pkg::PFP_ROUTE_OFF) |
                               (cec_pin_route_field_b != pfp_pkg::PFP_ROUTE_OFF));

  // Read word; reserved half always zero
  wire [PINS-1:0]  rd_low   = rd_fs ? fs_r[rd_idx] : (rd_pu ? pu_w[rd_idx] : '0);
  wire [31:0]      rd_word  = {pfp_pkg::PFP_RSV_ZERO, rd_low};
  wire [1:0]       rd_resp  = (rd_fs | rd_pu) ? pfp_pkg::PFP_RESP_OKAY
                                              : pfp_pkg::PFP_RESP_DECERR;
  wire [1:0]       wr_resp  = (wr_fs | wr_pu) ? pfp_pkg::PFP_RESP_OKAY
                                              : pfp_pkg::PFP_RESP_DECERR;

  // ==========================================================
  // AXI4-Lite write address and data capture, either order
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end
    else
    begin
      if (aw_hs)
      begin
        awaddr_r      <= s_axi_awaddr;
        aw_held_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_hs)
      begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_held_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        aw_held_r     <= 1'b0;
        w_held_r      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pfp_pkg::PFP_RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_resp;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Read channel: one cycle from address to data
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pfp_pkg::PFP_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_resp;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ==========================================================
  // Per-port register storage and pin mapping
  genvar p;
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_port
      localparam logic [15:0] RST_V  = (p == 0) ? pfp_pkg::PFP_P0_RST
                                                : pfp_pkg::PFP_PX_RST;
      localparam logic [15:0] KEEP_F = (p == 0) ? pfp_pkg::PFP_P0_KEEP : 16'h0000;
      localparam logic [15:0] CEC_M  = (p == CEC_PORT) ? CEC_PIN_MASK : 16'h0000;
      localparam logic [15:0] VB_M   = (p == pfp_pkg::PFP_VB_PORT) ?
                                       pfp_pkg::PFP_VB_MASK : 16'h0000;
      wire [PINS-1:0] keep = KEEP_F | (cec_on ? CEC_M : 16'h0000);

      assign wr_fs_en[p] = do_wr & wr_fs & (wr_idx == 4'(p));
      assign wr_pu_en[p] = do_wr & wr_pu & (wr_idx == 4'(p));

      // Function select: deep standby clears all but kept bits
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
          fs_r[p] <= RST_V;
        else if (dstby_reset)
          fs_r[p] <= (fs_r[p] & keep) | (RST_V & ~keep);
        else if (wr_fs_en[p])
          fs_r[p] <= (fs_r[p] & ~wr_mask) | (wdata_r[PINS-1:0] & wr_mask);
      end

      if (p == pfp_pkg::PFP_NO_PU_PORT)
      begin : g_no_pu
        // Slot reads zero, writes land nowhere
        assign pu_w[p] = '0;
      end
      else
      begin : g_pu
        logic [PINS-1:0] pu_r;
        // Pull-up: untouched by deep standby
        always_ff @(posedge core_clk)
        begin
          if (!rst_n)
            pu_r <= RST_V;
          else if (wr_pu_en[p])
            pu_r <= (pu_r & ~wr_mask) | (wdata_r[PINS-1:0] & wr_mask);
        end
        assign pu_w[p] = pu_r;
      end

      // Bit n of the port maps to pin n
      assign fs_eff[p*PINS +: PINS]  = fs_r[p] & ~VB_M;
      assign pu_flat[p*PINS +: PINS] = pu_w[p];
      assign vb_flat[p*PINS +: PINS] = VB_M;
    end
  endgenerate

  // ==========================================================
  // Registered pin controls
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_function_select <= '0;
      pin_gpio_select     <= '0;
      pin_pullup_enable   <= '0;
    end
    else
    begin
      pin_function_select <= fs_eff;
      pin_gpio_select     <= ~fs_eff & ~vb_flat;
      pin_pullup_enable   <= pu_flat & ~pin_output_active
                             & ~vb_flat;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_rsv_zero;
    s_axi_rvalid |-> (s_axi_rdata[31:16] == 16'h0000);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits nonzero");

  property p_readback;
    (do_wr & wr_fs & (wstrb_r[1:0] == 2'h3) & ~dstby_reset)
      |=> (fs_r[$past(wr_idx)] == $past(wdata_r[15:0]));
  endproperty
  a_readback: assert property (p_readback) else $error("select write lost");

  property p_gpio_path;
    rst_n |=> (pin_gpio_select == (~$past(fs_eff) & ~vb_flat));
  endproperty
  a_gpio_path: assert property (p_gpio_path) else $error("gpio select wrong");

  property p_periph_path;
    rst_n |=> (pin_function_select == $past(fs_eff));
  endproperty
  a_periph_path: assert property (p_periph_path) else $error("periph select lag");

  property p_reset_val;
    $rose(rst_n) |-> (fs_r[0] == pfp_pkg::PFP_P0_RST) && (fs_r[1] == 16'h0000)
                     && (pu_w[0] == pfp_pkg::PFP_P0_RST);
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset value");

  property p_vb_ignore;
    pin_function_select[pfp_pkg::PFP_VB_PORT*PINS+6 +: 4] == 4'h0;
  endproperty
  a_vb_ignore: assert property (p_vb_ignore) else $error("backup pins selected");

  property p_dstby_keep;
    dstby_reset |=> (fs_r[0][4:0] == $past(fs_r[0][4:0])) && (fs_r[0][15:5] == 11'h000);
  endproperty
  a_dstby_keep: assert property (p_dstby_keep) else $error("port0 keep wrong");

  property p_cec_keep;
    (dstby_reset & cec_on) |=>
      ((fs_r[CEC_PORT] & CEC_PIN_MASK) == $past(fs_r[CEC_PORT] & CEC_PIN_MASK));
  endproperty
  a_cec_keep: assert property (p_cec_keep) else $error("cec bits lost");

  property p_no_pu_drive;
    ##1 ((pin_pullup_enable & $past(pin_output_active)) == '0);
  endproperty
  a_no_pu_drive: assert property (p_no_pu_drive) else $error("pull-up on output");

  property p_pu_follow;
    rst_n |=> (pin_pullup_enable == ($past(pu_flat) & ~$past(pin_output_active) & ~vb_flat));
  endproperty
  a_pu_follow: assert property (p_pu_follow) else $error("pull-up mismatch");

  property p_no_pu_port;
    pin_pullup_enable[pfp_pkg::PFP_NO_PU_PORT*PINS +: PINS] == '0;
  endproperty
  a_no_pu_port: assert property (p_no_pu_port) else $error("port 8 pull-up");

  property p_bresp;
    (aw_held_r & w_held_r & ~s_axi_bvalid) |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("no write response");

  // Bus handshake checks
  property p_aw_refuse;
    aw_held_r |-> !s_axi_awready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("address taken twice");

  property p_w_refuse;
    w_held_r |-> !s_axi_wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("data taken twice");

  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");

  property p_rd_latency;
    ar_hs |=> (s_axi_rvalid && !s_axi_arready);
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read data late");

  property p_bvalid_one;
    (s_axi_bvalid & s_axi_bready) |=> (!s_axi_bvalid && s_axi_awready && s_axi_wready);
  endproperty
  a_bvalid_one: assert property (p_bvalid_one) else $error("write response stuck");

  property p_rvalid_one;
    (s_axi_rvalid & s_axi_rready) |=> (!s_axi_rvalid && s_axi_arready);
  endproperty
  a_rvalid_one: assert property (p_rvalid_one) else $error("read response stuck");

  property p_decerr_zero;
    (s_axi_rvalid & (s_axi_rresp == pfp_pkg::PFP_RESP_DECERR))
      |-> (s_axi_rdata == 32'h0000_0000);
  endproperty
  a_decerr_zero: assert property (p_decerr_zero) else $error("unmapped read nonzero");

  // Register content checks
  property p_pu_readback;
    (do_wr & wr_pu & (wstrb_r[1:0] == 2'h3) & (wr_idx != 4'(pfp_pkg::PFP_NO_PU_PORT)))
      |=> (pu_w[$past(wr_idx)] == $past(wdata_r[15:0]));
  endproperty
  a_pu_readback: assert property (p_pu_readback) else $error("pull-up write lost");

  property p_pu_dstby;
    (dstby_reset & ~do_wr) |=> $stable(pu_flat);
  endproperty
  a_pu_dstby: assert property (p_pu_dstby) else $error("pull-up hit by standby");

  property p_dstby_clear;
    (dstby_reset && (CEC_PORT != NPORT-1)) |=> (fs_r[NPORT-1] == '0);
  endproperty
  a_dstby_clear: assert property (p_dstby_clear) else $error("standby left bits");

  property p_pin_exclusive;
    (pin_gpio_select & pin_function_select) == '0;
  endproperty
  a_pin_exclusive: assert property (p_pin_exclusive) else $error("pin owned twice");

  c_fs_write: cover property (do_wr & wr_fs);
  c_pu_read:  cover property (ar_hs & rd_pu);
  c_dstby:    cover property (dstby_reset & cec_on);
  c_decerr:   cover property (s_axi_rvalid & (s_axi_rresp == pfp_pkg::PFP_RESP_DECERR));
  c_pu_write: cover property (do_wr & wr_pu);

endmodule : pfp_port_config

`default_nettype wire

/* tb_port_function_and_pullup_select.sv */
// Self-checking bench for the port function and pull-up select registers.
// Assumes pfp_pkg and pfp_port_config are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_port_function_and_pullup_select;
  // ==========================================================
  // Signals and model state
  localparam logic [15:0] P4M = pfp_pkg::PFP_VB_MASK;
  localparam logic [15:0] OSC_M = 16'h0000;  // Oscillator-shared select bits, none assumed
  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         dstby_reset = 1'b0;
  logic [1:0]   cfa = 2'h0;
  logic [1:0]   cfb = 2'h0;
  logic [255:0] outs = '0;
  logic [11:0]  s_axi_awaddr = 12'h000;
  logic         s_axi_awvalid = 1'b0;
  logic [31:0]  s_axi_wdata = 32'h0;
  logic [3:0]   s_axi_wstrb = 4'h0;
  logic         s_axi_wvalid = 1'b0;
  logic         s_axi_bready = 1'b0;
  logic [11:0]  s_axi_araddr = 12'h000;
  logic         s_axi_arvalid = 1'b0;
  logic         s_axi_rready = 1'b0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [31:0]  s_axi_rdata;
  logic [255:0] fsel, gsel, puen;
  logic [31:0]  seed = 32'h7182D1CA;
  logic [15:0]  fs_m [16];
  logic [15:0]  pu_m [16];
  int           errors = 0;
  int           checks = 0;

  // Port 2 pins 4 and 5 stand in for retained CEC pins
  pfp_port_config #(.CEC_PORT(2), .CEC_PIN_MASK(16'h0030), .CEC_RETAIN_EN(1'b1)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .dstby_reset(dstby_reset),
    .cec_pin_route_field_a(cfa), .cec_pin_route_field_b(cfb), .pin_output_active(outs),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_function_select(fsel), .pin_gpio_select(gsel), .pin_pullup_enable(puen)
  );

  // Clock, 4 ns period
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) aw_done = 1'b1;
      if (s_axi_wready === 1'b1) w_done = 1'b1;
      if (aw_done) s_axi_awvalid <= 1'b0;
      if (w_done) s_axi_wvalid <= 1'b0;
    end
    while (!(aw_done && w_done));
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // AXI4-Lite read
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Write register index i and update the model with byte strobes
  task automatic do_wr(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [1:0]  r;
    logic [15:0] cur;
    if (i < 16) d[15:0] = d[15:0] & ~OSC_M;
    wr(12'(i * 4), d, s, r);
    chk({30'h0, r}, {30'h0, pfp_pkg::PFP_RESP_OKAY});
    cur = (i < 16) ? fs_m[i] : pu_m[i - 16];
    if (s[0]) cur[7:0] = d[7:0];
    if (s[1]) cur[15:8] = d[15:8];
    if (i < 16) fs_m[i] = cur;
    else if (i != 24) pu_m[i - 16] = cur;
  endtask : do_wr

  // Read register index i against the model
  task automatic rd_chk(input int i);
    logic [31:0] d;
    logic [1:0]  r;
    rd(12'(i * 4), d, r);
    chk(d, {16'h0000, (i < 16) ? fs_m[i] : pu_m[i - 16]});
    chk({30'h0, r}, {30'h0, pfp_pkg::PFP_RESP_OKAY});
  endtask : rd_chk

  // Compare all pin outputs against the model
  task automatic chk_pins();
    logic [15:0] keep;
    for (int p = 0; p < 16; p++)
    begin
      keep = (p == 4) ? ~P4M : 16'hFFFF;
      chk({16'h0, fsel[p*16 +: 16]}, {16'h0, fs_m[p] & keep});
      chk({16'h0, gsel[p*16 +: 16]}, {16'h0, ~fs_m[p] & keep});
      chk({16'h0, puen[p*16 +: 16]},
          {16'h0, (p == 8) ? 16'h0 : pu_m[p] & ~outs[p*16 +: 16] & keep});
    end
  endtask : chk_pins

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] t;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 16; i++)
    begin
      fs_m[i] = (i == 0) ? pfp_pkg::PFP_P0_RST : pfp_pkg::PFP_PX_RST;
      pu_m[i] = fs_m[i];
    end
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values of every register and pin
    for (int i = 0; i < 32; i++) rd_chk(i);
    chk_pins();
    // Random writes with random strobes and pad directions
    repeat (64)
    begin
      t = xs();
      outs <= {xs(), xs(), xs(), xs(), xs(), xs(), xs(), xs()};
      do_wr(int'(t[20:16]), {16'h0000, t[15:0]}, t[24:21]);
      rd_chk(int'(t[20:16]));
      chk_pins();
    end
    // Unmapped address
    wr(12'h100, 32'h0000_0001, 4'hF, r);
    chk({30'h0, r}, {30'h0, pfp_pkg::PFP_RESP_DECERR});
    rd(12'h100, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, pfp_pkg::PFP_RESP_DECERR});
    // Deep standby with each route field, then with routing off
    for (int k = 0; k < 3; k++)
    begin
      for (int i = 0; i < 16; i++) do_wr(i, 32'h0000FFFF, 4'hF);
      cfa <= (k == 0) ? 2'h1 : 2'h0;
      cfb <= (k == 1) ? 2'h2 : 2'h0;
      @(posedge core_clk);
      dstby_reset <= 1'b1;
      @(posedge core_clk);
      dstby_reset <= 1'b0;
      for (int i = 0; i < 16; i++)
        fs_m[i] = (i == 0) ? fs_m[0] & pfp_pkg::PFP_P0_KEEP :
                  (i == 2 && k < 2) ? fs_m[2] & 16'h0030 : 16'h0000;
      for (int i = 0; i < 32; i++) rd_chk(i);
      chk_pins();
    end
    end_of_test();
  end

  // Watchdog
  initial
  begin
    #100000;
    errors++;
    end_of_test();
  end
endmodule : tb_port_function_and_pullup_select

`default_nettype wire
